// ===== rtl/mbox_pkg.sv
/*
 * Shared constants and types of the exchange-page mailbox: page map, field
 * positions, opcodes, result codes, carriers and the register state.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mbox_pkg;

	// ********************************
	// page map
	// ********************************
	localparam logic [7:0] PG_COMMAND = 8'h04;
	localparam logic [7:0] PG_ADDRESS = 8'h05;
	localparam logic [7:0] PG_COUNT = 8'h06;
	localparam logic [7:0] PG_RESULT = 8'h07;
	localparam logic [7:0] PG_DATA_FIRST = 8'h08;
	localparam logic [7:0] PG_DATA_LAST = 8'h6B;
	localparam logic [7:0] PG_START = 8'h85;
	localparam int DATA_PAGES = 100;
	localparam logic [15:0] MAX_WORDS = 16'h00C8;

	// ********************************
	// field positions and codes
	// ********************************
	localparam int TAG_LSB = 24;
	localparam int OP_LSB = 16;
	localparam int HIGH_LSB = 16;
	localparam logic [7:0] OP_READ = 8'h12;
	localparam logic [7:0] OP_WRITE = 8'h13;
	localparam logic [7:0] RES_ACK = 8'hAC;
	localparam logic [7:0] RES_FAIL = 8'hFC;
	localparam logic [31:0] PAGE_RST = 32'h0000_0000;
	localparam logic [15:0] LOW_RST = 16'h0000;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 32;

	// ********************************
	// carriers and state
	// ********************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] page;
		logic [31:0] wdata;
	} page_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} int_req_t;

	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READ, ST_WRITE, ST_REPLY} mbox_state_t;

	typedef struct packed {
		logic sync1;
		logic field_s;
		mbox_state_t fsm;
		logic [31:0] cmd;
		logic [31:0] addr;
		logic [31:0] cnt;
		logic [31:0] reply;
		logic [DATA_PAGES-1:0] valid;
		logic [7:0] exec_tag;
		logic [7:0] exec_op;
		logic [15:0] exec_addr;
		logic [15:0] exec_cnt;
		logic [15:0] issue_cnt;
		logic [15:0] drain_cnt;
		logic [7:0] result;
		logic [31:0] rdata;
		int_req_t bus;
		logic busy;
	} mbox_regs_t;

	localparam mbox_regs_t REGS_RST = '0;

endpackage

// ===== rtl/word_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flush input.
 * Assumes one clock; the flush discards all stored words in one cycle.
 */
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clr_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] fill;
	} fifo_regs_t;

	fifo_regs_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// ********************************
	// handshake
	// ********************************
	assign in_ready_o = (s_q.fill != (AW+1)'(DEPTH));
	assign out_valid_o = (s_q.fill != '0);
	assign out_data_o = mem[s_q.rd];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointer and fill update
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.fill = s_q.fill + (AW+1)'(push) - (AW+1)'(pop);
		if (clr_i) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// storage, written only on an accepted word
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[s_q.wr] <= in_data_i;
		end
	end

endmodule

// ===== rtl/nfc_exchange_mailbox.sv
/*
 * Exchange-page mailbox between a contactless reader and the controller's
 * internal 16-bit registers. Page accesses arrive already decoded and on
 * clk_i; field_present_i is an asynchronous pin.
 */
`timescale 1ns/1ps
module nfc_exchange_mailbox import mbox_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic field_present_i,
	input wire page_req_t page_req_i,
	output logic [31:0] page_rdata_o,
	output int_req_t int_bus_o,
	input wire logic int_ack_i,
	input wire logic [15:0] int_rdata_i,
	output logic busy_o
);

	mbox_regs_t s_q, s_d;
	logic [31:0] data_mem [DATA_PAGES];
	logic rdr_access, rdr_data, start;
	logic [7:0] rdr_off;
	logic [6:0] rdr_idx, dev_idx;
	logic [15:0] dev_cnt;
	logic [31:0] dev_page, merged;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, drain_fire;
	logic [15:0] fifo_out_data;

	// ********************************
	// page decode and device-side page access
	// ********************************
	assign rdr_access = page_req_i.rd | page_req_i.wr;
	assign rdr_data = (page_req_i.page >= PG_DATA_FIRST) && (page_req_i.page <= PG_DATA_LAST);
	assign rdr_off = 8'(page_req_i.page - PG_DATA_FIRST);
	assign rdr_idx = rdr_off[6:0];
	assign start = page_req_i.wr && (page_req_i.page == PG_START) && (s_q.fsm == ST_IDLE)
		&& s_q.field_s;
	assign dev_cnt = (s_q.fsm == ST_READ) ? s_q.drain_cnt : s_q.issue_cnt;
	assign dev_idx = dev_cnt[7:1];
	// index past the window (count fully done) reads as empty, not as unknown
	assign dev_page = (dev_idx < 7'(DATA_PAGES) && s_q.valid[dev_idx])
		? data_mem[dev_idx] : PAGE_RST;
	// even word fills upper half, odd word the lower half
	assign merged = dev_cnt[0] ? {dev_page[31:HIGH_LSB], fifo_out_data}
		: {fifo_out_data, dev_page[HIGH_LSB-1:0]};

	// read data path: internal answers into the FIFO, FIFO into pages
	assign fifo_in_valid = s_q.bus.req & ~s_q.bus.we & int_ack_i;
	assign fifo_out_ready = (s_q.fsm == ST_READ) & ~rdr_access & s_q.field_s;
	assign drain_fire = fifo_out_valid & fifo_out_ready;

	word_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_read_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.clr_i(~s_q.field_s),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(int_rdata_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// ********************************
	// next state
	// ********************************
	always_comb begin
		s_d = s_q;
		s_d.sync1 = field_present_i;
		s_d.field_s = s_q.sync1;
		// reader page read, answered one cycle later
		if (page_req_i.rd) begin
			case (page_req_i.page)
				PG_COMMAND: s_d.rdata = s_q.cmd;
				PG_ADDRESS: s_d.rdata = s_q.addr;
				PG_COUNT: s_d.rdata = s_q.cnt;
				PG_RESULT: s_d.rdata = s_q.reply;
				default: begin
					s_d.rdata = (rdr_data && s_q.valid[rdr_idx]) ? data_mem[rdr_idx] : PAGE_RST;
				end
			endcase
		end
		// reader page write into the parameter pages
		if (page_req_i.wr && s_q.field_s) begin
			case (page_req_i.page)
				PG_COMMAND: s_d.cmd = page_req_i.wdata;
				PG_ADDRESS: s_d.addr = page_req_i.wdata;
				PG_COUNT: s_d.cnt = page_req_i.wdata;
				PG_RESULT: s_d.reply = page_req_i.wdata;
				default: begin
					if (rdr_data) begin
						s_d.valid[rdr_idx] = 1'b1;
					end
				end
			endcase
		end
		case (s_q.fsm)
			ST_IDLE: begin
				// snapshot of the pages loaded before the start write
				if (start) begin
					s_d.exec_tag = s_q.cmd[TAG_LSB +: 8];
					s_d.exec_op = s_q.cmd[OP_LSB +: 8];
					s_d.exec_addr = s_q.addr[HIGH_LSB +: 16];
					s_d.exec_cnt = s_q.cnt[HIGH_LSB +: 16];
					s_d.issue_cnt = '0;
					s_d.drain_cnt = '0;
					s_d.fsm = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// unknown opcode or oversize count fails without any access
				if (((s_q.exec_op != OP_READ) && (s_q.exec_op != OP_WRITE))
					|| (s_q.exec_cnt > MAX_WORDS)) begin
					s_d.result = RES_FAIL;
					s_d.fsm = ST_REPLY;
				end else if (s_q.exec_op == OP_READ) begin
					s_d.fsm = ST_READ;
				end else begin
					s_d.fsm = ST_WRITE;
				end
			end
			ST_READ: begin
				// one internal read at a time, only while the FIFO has room
				if (s_q.bus.req) begin
					if (int_ack_i) begin
						s_d.bus.req = 1'b0;
						s_d.issue_cnt = s_q.issue_cnt + 16'h0001;
					end
				end else if ((s_q.issue_cnt < s_q.exec_cnt) && fifo_in_ready) begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b0;
					s_d.bus.addr = 16'(s_q.exec_addr + s_q.issue_cnt);
				end
				if (drain_fire) begin
					s_d.valid[dev_idx] = 1'b1;
					s_d.drain_cnt = s_q.drain_cnt + 16'h0001;
				end
				// reply only once every word sits in the pages
				if (s_q.drain_cnt == s_q.exec_cnt) begin
					s_d.result = RES_ACK;
					s_d.fsm = ST_REPLY;
				end
			end
			ST_WRITE: begin
				// fetch each word from its page half while the reader is quiet
				if (s_q.bus.req) begin
					if (int_ack_i) begin
						s_d.bus.req = 1'b0;
						s_d.issue_cnt = s_q.issue_cnt + 16'h0001;
					end
				end else if (s_q.issue_cnt == s_q.exec_cnt) begin
					s_d.result = RES_ACK;
					s_d.fsm = ST_REPLY;
				end else if (!rdr_access) begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b1;
					s_d.bus.addr = 16'(s_q.exec_addr + s_q.issue_cnt);
					s_d.bus.wdata = s_q.issue_cnt[0] ? dev_page[HIGH_LSB-1:0]
						: dev_page[31:HIGH_LSB];
				end
			end
			ST_REPLY: begin
				// post tag echo and result when the reader is not on the pages
				if (!rdr_access) begin
					s_d.reply = {s_q.exec_tag, s_q.result, LOW_RST};
					s_d.fsm = ST_IDLE;
				end
			end
			default: s_d.fsm = ST_IDLE;
		endcase
		// field loss discards all volatile page content
		if (!s_q.field_s) begin
			s_d = REGS_RST;
			s_d.sync1 = field_present_i;
			s_d.field_s = s_q.sync1;
		end
		s_d.busy = (s_d.fsm != ST_IDLE);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= REGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ********************************
	// data pages, reader write first
	// ********************************
	always_ff @(posedge clk_i) begin
		if (page_req_i.wr && rdr_data && s_q.field_s) begin
			data_mem[rdr_idx] <= page_req_i.wdata;
		end else if (drain_fire) begin
			data_mem[dev_idx] <= merged;
		end
	end

	assign page_rdata_o = s_q.rdata;
	assign int_bus_o = s_q.bus;
	assign busy_o = s_q.busy;

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	property p_start;
		start |=> (s_q.fsm == ST_CHECK) ##1 (s_q.fsm != ST_IDLE);
	endproperty
	a_start: assert property (p_start) else $error("start write not taken");

	property p_cmd_page;
		(s_q.field_s && page_req_i.wr && page_req_i.page == PG_COMMAND)
			|=> (s_q.cmd == $past(page_req_i.wdata));
	endproperty
	a_cmd_page: assert property (p_cmd_page) else $error("command page not stored");

	property p_bad_op;
		(s_q.field_s && s_q.fsm == ST_CHECK && s_q.exec_op != OP_READ && s_q.exec_op != OP_WRITE)
			|=> (s_q.fsm == ST_REPLY && s_q.result == RES_FAIL);
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("unknown opcode not failed");

	property p_oversize;
		(s_q.field_s && s_q.fsm == ST_CHECK && s_q.exec_cnt > MAX_WORDS)
			|=> (s_q.result == RES_FAIL) ##1 !s_q.bus.req;
	endproperty
	a_oversize: assert property (p_oversize) else $error("oversize count not failed");

	property p_echo;
		(s_q.field_s && s_q.fsm == ST_REPLY && !rdr_access)
			|=> (s_q.reply[TAG_LSB +: 8] == $past(s_q.exec_tag)
			&& s_q.reply[OP_LSB +: 8] == $past(s_q.result) && s_q.fsm == ST_IDLE);
	endproperty
	a_echo: assert property (p_echo) else $error("reply page wrong");

	property p_data_first;
		(s_q.fsm == ST_READ) ##1 (s_q.fsm == ST_REPLY)
			|-> (s_q.drain_cnt == s_q.exec_cnt && !fifo_out_valid);
	endproperty
	a_data_first: assert property (p_data_first) else $error("reply before data");

	property p_addr;
		$rose(s_q.bus.req) |-> (s_q.bus.addr == 16'(s_q.exec_addr + s_q.issue_cnt));
	endproperty
	a_addr: assert property (p_addr) else $error("internal address not consecutive");

	property p_half;
		($rose(s_q.bus.req) && s_q.bus.we) |-> (s_q.bus.wdata
			== (s_q.issue_cnt[0] ? dev_page[15:0] : dev_page[31:16]));
	endproperty
	a_half: assert property (p_half) else $error("write word from wrong half");

	property p_no_collide;
		($rose(s_q.bus.req) && s_q.bus.we) |-> !$past(rdr_access);
	endproperty
	a_no_collide: assert property (p_no_collide) else $error("page fetch during reader");

	property p_field;
		!s_q.field_s |=> (s_q.valid == '0 && s_q.fsm == ST_IDLE && !s_q.bus.req);
	endproperty
	a_field: assert property (p_field) else $error("state kept after field loss");

	property p_req_state;
		s_q.bus.req |-> (s_q.fsm == ST_READ || s_q.fsm == ST_WRITE);
	endproperty
	a_req_state: assert property (p_req_state) else $error("internal access outside run");

	property p_read_reply;
		(s_q.field_s && page_req_i.rd && page_req_i.page == PG_RESULT)
			|=> (page_rdata_o == $past(s_q.reply));
	endproperty
	a_read_reply: assert property (p_read_reply) else $error("reply page read wrong");

	property p_result_code;
		(s_q.fsm == ST_REPLY) |-> (s_q.result == RES_ACK || s_q.result == RES_FAIL);
	endproperty
	a_result_code: assert property (p_result_code) else $error("result code not legal");

endmodule

// ===== dv/int_reg_model.sv
/*
 * Behavioural internal register file that answers the mailbox's req/ack bus.
 * Assumes req is held until ack, ack is a one-cycle pulse, one clock.
 */
`timescale 1ns/1ps
module int_reg_model import mbox_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire int_req_t bus_i,
	input wire logic [3:0] delay_i,
	output logic ack_o,
	output logic [15:0] rdata_o,
	output int acc_o
);
	// ****
	// storage
	// ****
	logic [15:0] mem [0:511];
	logic [3:0] wait_q;
	logic [15:0] last_q;

	// registers start cleared
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 16'h0000;
		end
	end

	// answer each held request once, after delay_i waiting cycles
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_o <= 1'b0;
			wait_q <= 4'h0;
			acc_o <= 0;
			last_q <= 16'h0000;
		end else begin
			ack_o <= 1'b0;
			if (bus_i.req && !ack_o && wait_q < delay_i) begin
				wait_q <= wait_q + 4'h1;
			end else if (bus_i.req && !ack_o) begin
				ack_o <= 1'b1;
				wait_q <= 4'h0;
				acc_o <= acc_o + 1;
				if (bus_i.we) begin
					mem[bus_i.addr[8:0]] <= bus_i.wdata;
				end
				last_q <= mem[bus_i.addr[8:0]];
			end
		end
	end

	// read data is valid only with ack; otherwise the inverse of the last word
	assign rdata_o = ack_o ? last_q : ~last_q;
endmodule

// ===== dv/nfc_exchange_mailbox_bench.sv
/*
 * Self-checking bench for the exchange-page mailbox, acting as the reader.
 * Assumes the mailbox package and the internal register model.
 */
`timescale 1ns/1ps
module nfc_exchange_mailbox_bench import mbox_pkg::*;;
	// ****
	// signals and instances
	// ****
	logic clk;
	logic rst_b;
	logic field;
	page_req_t req;
	logic [31:0] rdata;
	int_req_t bus;
	logic ack;
	logic [15:0] irdata;
	logic busy;
	logic [3:0] delay;
	int acc;
	int num_errors;
	int checked;
	int a0;

	nfc_exchange_mailbox DUT (.clk_i(clk), .rst_b_i(rst_b), .field_present_i(field),
		.page_req_i(req), .page_rdata_o(rdata), .int_bus_o(bus), .int_ack_i(ack),
		.int_rdata_i(irdata), .busy_o(busy));
	int_reg_model model (.clk_i(clk), .rst_b_i(rst_b), .bus_i(bus), .delay_i(delay),
		.ack_o(ack), .rdata_o(irdata), .acc_o(acc));

	// clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****
	// shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one page access, then one idle cycle
	task automatic pg(input logic rd, input logic [7:0] page, input logic [31:0] wd,
		output logic [31:0] rd_data);
		req = '{rd: rd, wr: !rd, page: page, wdata: wd};
		@(posedge clk);
		#1;
		req = '0;
		rd_data = rdata;
		@(posedge clk);
		#1;
	endtask

	task automatic pg_wr(input logic [7:0] page, input logic [31:0] wd);
		logic [31:0] unused;
		pg(1'b0, page, wd, unused);
	endtask

	task automatic pg_chk(input logic [7:0] page, input logic [31:0] exp);
		logic [31:0] r;
		pg(1'b1, page, 32'h0000_0000, r);
		check(r, exp);
	endtask

	// load parameters, trigger once, wait for busy to fall, poll reply for the tag
	task automatic run_cmd(input logic [7:0] tag, input logic [7:0] op,
		input logic [15:0] addr, input logic [15:0] cnt, input logic [7:0] res);
		logic [31:0] r;
		int n;
		pg_wr(PG_COMMAND, {tag, op, 16'h5A5A});
		pg_wr(PG_ADDRESS, {addr, 16'hFFFF});
		pg_wr(PG_COUNT, {cnt, 16'h3C3C});
		pg_wr(PG_START, 32'h0000_0000);
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 5000) begin
			num_errors++;
			final_report();
		end
		r = 32'h0000_0000;
		n = 0;
		while (r[31:24] !== tag && n < 4) begin
			pg(1'b1, PG_RESULT, 32'h0000_0000, r);
			n++;
		end
		check(r, {tag, res, 16'h0000});
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		check(rdata, 32'h0000_0000);
		check({13'h0000, busy, bus.req, bus.we, bus.addr}, 32'h0000_0000);
	endtask

	task automatic t_write();
		a0 = acc;
		pg_wr(PG_DATA_FIRST, 32'h1234_5678);
		pg_wr(PG_DATA_FIRST + 8'h01, 32'hABCD_FFFF);
		run_cmd(8'h01, OP_WRITE, 16'h0010, 16'h0003, RES_ACK);
		check({16'h0000, model.mem[16]}, 32'h0000_1234);
		check({16'h0000, model.mem[17]}, 32'h0000_5678);
		check({16'h0000, model.mem[18]}, 32'h0000_ABCD);
		check(acc - a0, 32'h0000_0003);
	endtask

	task automatic t_read();
		delay = 4'h5;
		pg_wr(PG_DATA_FIRST, 32'h0000_0000);
		pg_wr(PG_DATA_FIRST + 8'h01, 32'h0000_5A5A);
		run_cmd(8'h02, OP_READ, 16'h0010, 16'h0003, RES_ACK);
		pg_chk(PG_DATA_FIRST, 32'h1234_5678);
		pg_chk(PG_DATA_FIRST + 8'h01, 32'hABCD_5A5A);
		delay = 4'h0;
	endtask

	task automatic t_refuse();
		a0 = acc;
		run_cmd(8'h03, 8'h55, 16'h0011, 16'h0001, RES_FAIL);
		run_cmd(8'h04, OP_WRITE, 16'h0011, 16'h00C9, RES_FAIL);
		check(acc - a0, 32'h0000_0000);
		check({16'h0000, model.mem[17]}, 32'h0000_5678);
		pg_chk(PG_DATA_LAST + 8'h01, 32'h0000_0000);
		pg_chk(8'h70, 32'h0000_0000);
	endtask

	task automatic t_limits();
		a0 = acc;
		run_cmd(8'h05, OP_READ, 16'h0010, 16'h0000, RES_ACK);
		check(acc - a0, 32'h0000_0000);
		pg_wr(PG_DATA_LAST, 32'hFFFF_FFFF);
		run_cmd(8'h06, OP_READ, 16'h0010, 16'h00C8, RES_ACK);
		check(acc - a0, 32'h0000_00C8);
		pg_chk(PG_DATA_FIRST + 8'h01, 32'hABCD_0000);
		pg_chk(PG_DATA_LAST, 32'h0000_0000);
	endtask

	task automatic t_field();
		logic [31:0] r;
		pg(1'b1, PG_COMMAND, 32'h0000_0000, r);
		check({16'h0000, r[31:16]}, {16'h0000, 8'h06, OP_READ});
		pg_wr(PG_RESULT, 32'h5A3C_0000);
		pg_chk(PG_RESULT, 32'h5A3C_0000);
		field = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		field = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		for (int p = 4; p < 10; p++) begin
			pg_chk(p[7:0], 32'h0000_0000);
		end
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		num_errors = 0;
		checked = 0;
		rst_b = 1'b0;
		field = 1'b1;
		delay = 4'h0;
		req = '0;
		repeat (8) @(posedge clk);
		#1;
		t_reset();
		rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_write();
		t_read();
		t_refuse();
		t_limits();
		t_field();
		final_report();
	end
endmodule
